// [rtl/ccpcm_regs.vh]
// Constants for the codec control port and PCM framing logic.
// Assumes one 50 MHz clock; all pins except rst_n_i are already synchronous to it.
`ifndef CCPCM_REGS_VH
`define CCPCM_REGS_VH

`define CCPCM_ADDR_CTRL 4'h0
`define CCPCM_ADDR_LATCH 4'h1
`define CCPCM_ADDR_LDIR 4'h2
`define CCPCM_ADDR_RXGAIN 4'h4
`define CCPCM_ADDR_TXGAIN 4'h5
`define CCPCM_ADDR_RXSLOT 4'h9
`define CCPCM_ADDR_TXSLOT 4'hA
`define CCPCM_NUM_REGS 16

`define CCPCM_B1_PWR 7
`define CCPCM_B1_ADDR 6:3
`define CCPCM_B1_RD 2
`define CCPCM_B1_LEN 1

`define CCPCM_CTRL_RATE 7:6
`define CCPCM_CTRL_LAW 5
`define CCPCM_CTRL_INV 4
`define CCPCM_CTRL_DN 3
`define CCPCM_CTRL_DL 2
`define CCPCM_CTRL_AL 1
`define CCPCM_CTRL_PP 0
`define CCPCM_CTRL_RST 8'h89
`define CCPCM_OTHER_RST 8'h00

`define CCPCM_SLOT_EN 7
`define CCPCM_SLOT_NUM 5:0

`define CCPCM_IDLE_MU 8'hFF
`define CCPCM_IDLE_A_INV 8'hD5
`define CCPCM_IDLE_A_RAW 8'h80

`define CCPCM_LAST_BIT 3'h7
`define CCPCM_WAKE_FRAMES 2'h2
`define CCPCM_POS_W 10
`define CCPCM_FIFO_DEPTH 4
`define CCPCM_FIFO_AW 2

`endif

// [rtl/ccpcm_top.v]
// Codec serial control port, register file and PCM slot framing.
// Assumes shift clock, bit clock and frame marks are sampled pins,
// each level held at least two clock_i periods.
`include "ccpcm_regs.vh"

// ----------------------------------------------------------------
// Transmit byte FIFO
// ----------------------------------------------------------------
module ccpcm_fifo #(
    parameter W = 8,
    parameter D = 4,
    parameter AW = 2
) (
    input wire clock_i,
    input wire rst_n_i,
    input wire [W-1:0] in_data_i,
    input wire in_valid_i,
    output wire in_ready_o,
    output wire [W-1:0] out_data_o,
    output wire out_valid_o,
    input wire out_ready_i
);
    reg [W-1:0] mem_q [0:D-1];
    reg [AW-1:0] wr_q;
    reg [AW-1:0] rd_q;
    reg [AW:0] cnt_q;
    wire push = in_valid_i && (cnt_q != D);
    wire pop = out_ready_i && (cnt_q != 0);
    assign in_ready_o = (cnt_q != D);
    assign out_valid_o = (cnt_q != 0);
    assign out_data_o = mem_q[rd_q];

    always @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wr_q <= {AW{1'b0}};
            rd_q <= {AW{1'b0}};
            cnt_q <= {(AW+1){1'b0}};
        end else begin
            if (push)
                wr_q <= wr_q + 1'b1;
            if (pop)
                rd_q <= rd_q + 1'b1;
            if (push && !pop)
                cnt_q <= cnt_q + 1'b1;
            else if (pop && !push)
                cnt_q <= cnt_q - 1'b1;
        end
    end

    // Storage needs no reset; empty entries are never read out
    always @(posedge clock_i) begin
        if (push)
            mem_q[wr_q] <= in_data_i;
    end
endmodule // ccpcm_fifo

// ----------------------------------------------------------------
// Top level
// ----------------------------------------------------------------
module ccpcm_top (
    input wire clock_i,
    input wire rst_n_i,
    input wire ctrl_shift_clk_i,
    input wire select_n_i,
    input wire serial_in_pin_i,
    output wire serial_out_pin_o,
    output wire serial_out_pin_oe_o,
    input wire bit_clk_i,
    input wire tx_frame_mark_i,
    input wire rx_frame_mark_i,
    output wire tx_serial_out_o,
    output wire tx_serial_out_oe_o,
    output wire tx_slot_active_n_o,
    output wire tx_slot_active_n_oe_o,
    input wire rx_serial_in_i,
    input wire [7:0] tx_pcm_data_i,
    input wire tx_pcm_valid_i,
    output wire tx_pcm_ready_o,
    output wire [7:0] rx_pcm_data_o,
    output wire rx_pcm_strobe_o,
    output wire sleep_state_o,
    output wire [1:0] clock_rate_sel_o,
    output wire law_choice_o,
    output wire inversion_off_o,
    output wire frame_timing_sel_o,
    output wire pcm_echo_o,
    output wire audio_loop_o,
    output wire amp_enable_o
);
    // ------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------
    reg [1:0] rst_sync_q;
    wire rst_n = rst_sync_q[1];
    always @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i)
            rst_sync_q <= 2'b00;
        else
            rst_sync_q <= {rst_sync_q[0], 1'b1};
    end

    // ------------------------------------------------------------
    // Serial control port
    // ------------------------------------------------------------
    reg ctrl_shift_clk_q;
    reg [2:0] bit_cnt_q;
    reg byte2_q;
    reg rd_q;
    reg [3:0] addr_q;
    reg [7:0] sh_q;
    reg [7:0] out_q;
    reg so_q;
    reg sleep_q;
    wire [127:0] reg_flat;
    wire ctrl_shift_clk_fall = ctrl_shift_clk_q && !ctrl_shift_clk_i;
    wire ctrl_shift_clk_rise = !ctrl_shift_clk_q && ctrl_shift_clk_i;
    wire [7:0] sh_d = {sh_q[6:0], serial_in_pin_i};
    wire byte_done = ctrl_shift_clk_fall && !select_n_i && (bit_cnt_q == `CCPCM_LAST_BIT);
    wire wr_en = byte_done && byte2_q && !rd_q;
    wire [7:0] rd_val = reg_flat[{sh_d[`CCPCM_B1_ADDR], 3'b000} +: 8];

    always @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_shift_clk_q <= 1'b0;
            bit_cnt_q <= 3'h0;
            byte2_q <= 1'b0;
            rd_q <= 1'b0;
            addr_q <= 4'h0;
            sh_q <= 8'h00;
            out_q <= 8'h00;
            so_q <= 1'b0;
            sleep_q <= 1'b1;
        end else begin
            ctrl_shift_clk_q <= ctrl_shift_clk_i;
            if (select_n_i) begin
                // Aborted byte drops the instruction; a rise between bytes keeps byte 2 pending
                bit_cnt_q <= 3'h0;
                if (bit_cnt_q != 3'h0)
                    byte2_q <= 1'b0;
            end else begin
                if (ctrl_shift_clk_fall) begin
                    sh_q <= sh_d;
                    bit_cnt_q <= bit_cnt_q + 3'h1;
                end
                if (byte_done && !byte2_q) begin
                    sleep_q <= sh_d[`CCPCM_B1_PWR];
                    byte2_q <= sh_d[`CCPCM_B1_LEN];
                    addr_q <= sh_d[`CCPCM_B1_ADDR];
                    rd_q <= sh_d[`CCPCM_B1_RD];
                    out_q <= rd_val;
                end else if (byte_done) begin
                    byte2_q <= 1'b0;
                end
                if (ctrl_shift_clk_rise && byte2_q && rd_q) begin
                    so_q <= out_q[7];
                    out_q <= {out_q[6:0], 1'b0};
                end
            end
        end
    end

    assign serial_out_pin_o = so_q;
    assign serial_out_pin_oe_o = !select_n_i && byte2_q && rd_q;

    // ------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < `CCPCM_NUM_REGS; g = g + 1) begin : g_reg
            localparam [3:0] IDX = g;
            localparam VALID = (IDX == `CCPCM_ADDR_CTRL) || (IDX == `CCPCM_ADDR_LATCH) ||
                (IDX == `CCPCM_ADDR_LDIR) || (IDX == `CCPCM_ADDR_RXGAIN) ||
                (IDX == `CCPCM_ADDR_TXGAIN) || (IDX == `CCPCM_ADDR_RXSLOT) ||
                (IDX == `CCPCM_ADDR_TXSLOT);
            localparam [7:0] RST = (IDX == `CCPCM_ADDR_CTRL) ? `CCPCM_CTRL_RST : `CCPCM_OTHER_RST;
            if (VALID) begin : g_valid
                reg [7:0] val_q;
                always @(posedge clock_i or negedge rst_n) begin
                    if (!rst_n)
                        val_q <= RST;
                    else if (wr_en && addr_q == IDX)
                        val_q <= sh_d;
                end
                assign reg_flat[g*8 +: 8] = val_q;
            end else begin : g_invalid
                // Invalid codes hold nothing and read back zero
                assign reg_flat[g*8 +: 8] = 8'h00;
            end
        end
    endgenerate

    wire [7:0] ctrl = reg_flat[{`CCPCM_ADDR_CTRL, 3'b000} +: 8];
    wire [7:0] rxslot = reg_flat[{`CCPCM_ADDR_RXSLOT, 3'b000} +: 8];
    wire [7:0] txslot = reg_flat[{`CCPCM_ADDR_TXSLOT, 3'b000} +: 8];

    assign sleep_state_o = sleep_q;
    assign clock_rate_sel_o = ctrl[`CCPCM_CTRL_RATE];
    assign law_choice_o = ctrl[`CCPCM_CTRL_LAW];
    assign inversion_off_o = ctrl[`CCPCM_CTRL_INV];
    assign frame_timing_sel_o = ctrl[`CCPCM_CTRL_DN];
    assign pcm_echo_o = ctrl[`CCPCM_CTRL_DL];
    assign audio_loop_o = ctrl[`CCPCM_CTRL_AL] && !ctrl[`CCPCM_CTRL_DL];
    assign amp_enable_o = !sleep_q || !ctrl[`CCPCM_CTRL_PP];

    // ------------------------------------------------------------
    // Frame-aligned copy of control and wake-up gate
    // ------------------------------------------------------------
    reg [7:0] pcm_ctrl_q;
    reg [1:0] wake_q;
    reg [1:0] fs_q;
    reg bclk_q;
    wire [1:0] fs_in = {rx_frame_mark_i, tx_frame_mark_i};
    wire tx_fs_rise = tx_frame_mark_i && !fs_q[0];

    // Mode changes only land on a transmit frame boundary; slot register writes and power-down act at once and can cut a transmit slot
    always @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            pcm_ctrl_q <= `CCPCM_CTRL_RST;
            wake_q <= 2'h0;
            fs_q <= 2'b00;
            bclk_q <= 1'b0;
        end else begin
            fs_q <= fs_in;
            bclk_q <= bit_clk_i;
            if (tx_fs_rise)
                pcm_ctrl_q <= ctrl;
            if (sleep_q)
                wake_q <= 2'h0;
            else if (tx_fs_rise && wake_q != `CCPCM_WAKE_FRAMES)
                wake_q <= wake_q + 2'h1;
        end
    end

    wire awake = !sleep_q && (wake_q == `CCPCM_WAKE_FRAMES);
    wire delayed = !pcm_ctrl_q[`CCPCM_CTRL_DN];
    wire bclk_rise = bit_clk_i && !bclk_q;
    wire bclk_fall = !bit_clk_i && bclk_q;

    // ------------------------------------------------------------
    // Slot position counters: channel 0 transmit, 1 receive
    // ------------------------------------------------------------
    wire [`CCPCM_POS_W*2-1:0] pos_flat;
    wire [`CCPCM_POS_W*2-1:0] pos_nx_flat;
    wire [1:0] act_nx;
    wire [1:0] act_now;
    wire [7:0] slot_reg [0:1];
    assign slot_reg[0] = txslot;
    assign slot_reg[1] = rxslot;

    generate
        for (g = 0; g < 2; g = g + 1) begin : g_chan
            reg [`CCPCM_POS_W-1:0] pos_q;
            reg fs_rise_q;
            reg fs_fall_q;
            reg armed_q;
            wire nd_start = fs_in[g] && !fs_rise_q;
            wire start = delayed ? armed_q : nd_start;
            wire [`CCPCM_POS_W-1:0] pos_nx = start ? {`CCPCM_POS_W{1'b0}} :
                (pos_q[`CCPCM_POS_W-1] ? pos_q : pos_q + 1'b1);
            // Slot counting is forced to slot zero outside delayed timing
            wire [5:0] target = delayed ? slot_reg[g][`CCPCM_SLOT_NUM] : 6'h00;
            wire en = slot_reg[g][`CCPCM_SLOT_EN] && awake;
            assign act_nx[g] = en && !pos_nx[`CCPCM_POS_W-1] && pos_nx[8:3] == target;
            assign act_now[g] = en && !pos_q[`CCPCM_POS_W-1] && pos_q[8:3] == target;
            assign pos_flat[g*`CCPCM_POS_W +: `CCPCM_POS_W] = pos_q;
            assign pos_nx_flat[g*`CCPCM_POS_W +: `CCPCM_POS_W] = pos_nx;
            always @(posedge clock_i or negedge rst_n) begin
                if (!rst_n) begin
                    pos_q <= {1'b1, {(`CCPCM_POS_W-1){1'b0}}};
                    fs_rise_q <= 1'b0;
                    fs_fall_q <= 1'b0;
                    armed_q <= 1'b0;
                end else begin
                    if (bclk_rise) begin
                        pos_q <= pos_nx;
                        fs_rise_q <= fs_in[g];
                        armed_q <= 1'b0;
                    end
                    if (bclk_fall) begin
                        // Mark seen high half a bit early opens slot zero
                        fs_fall_q <= fs_in[g];
                        if (fs_in[g] && !fs_fall_q)
                            armed_q <= 1'b1;
                    end
                end
            end
        end
    endgenerate

    wire [`CCPCM_POS_W-1:0] tx_pos_nx = pos_nx_flat[0 +: `CCPCM_POS_W];
    wire [`CCPCM_POS_W-1:0] tx_pos = pos_flat[0 +: `CCPCM_POS_W];
    wire [`CCPCM_POS_W-1:0] rx_pos = pos_flat[`CCPCM_POS_W +: `CCPCM_POS_W];

    // ------------------------------------------------------------
    // Transmit and receive shifters
    // ------------------------------------------------------------
    wire [7:0] fifo_data;
    wire fifo_valid;
    reg [7:0] tx_byte_q;
    reg tx_q;
    reg tx_oe_q;
    reg ts_q;
    reg [7:0] rx_sh_q;
    reg [7:0] rx_byte_q;
    reg rx_stb_q;
    wire tx_load = bclk_rise && act_nx[0] && tx_pos_nx[2:0] == 3'h0;
    wire echo = pcm_ctrl_q[`CCPCM_CTRL_DL];
    wire fifo_pop = tx_load && !echo;
    wire [7:0] idle_code = !pcm_ctrl_q[`CCPCM_CTRL_LAW] ? `CCPCM_IDLE_MU :
        (pcm_ctrl_q[`CCPCM_CTRL_INV] ? `CCPCM_IDLE_A_RAW : `CCPCM_IDLE_A_INV);
    // An empty FIFO sends silence rather than stalling the backplane
    wire [7:0] tx_src = echo ? rx_byte_q : (fifo_valid ? fifo_data : idle_code);
    wire [7:0] rx_sh_d = {rx_sh_q[6:0], rx_serial_in_i};

    ccpcm_fifo #(
        .W(8),
        .D(`CCPCM_FIFO_DEPTH),
        .AW(`CCPCM_FIFO_AW)
    ) u_tx_fifo (
        .clock_i(clock_i),
        .rst_n_i(rst_n),
        .in_data_i(tx_pcm_data_i),
        .in_valid_i(tx_pcm_valid_i),
        .in_ready_o(tx_pcm_ready_o),
        .out_data_o(fifo_data),
        .out_valid_o(fifo_valid),
        .out_ready_i(fifo_pop)
    );

    always @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            tx_byte_q <= 8'h00;
            tx_q <= 1'b0;
            tx_oe_q <= 1'b0;
            ts_q <= 1'b0;
            rx_sh_q <= 8'h00;
            rx_byte_q <= 8'h00;
            rx_stb_q <= 1'b0;
        end else begin
            rx_stb_q <= 1'b0;
            if (bclk_rise) begin
                tx_oe_q <= act_nx[0];
                ts_q <= act_nx[0];
                if (tx_load) begin
                    tx_byte_q <= tx_src;
                    tx_q <= tx_src[7];
                end else begin
                    tx_q <= tx_byte_q[~tx_pos_nx[2:0]];
                end
            end
            if (bclk_fall) begin
                if (act_now[0] && tx_pos[2:0] == `CCPCM_LAST_BIT)
                    ts_q <= 1'b0;
                if (act_now[1]) begin
                    rx_sh_q <= rx_sh_d;
                    if (rx_pos[2:0] == `CCPCM_LAST_BIT) begin
                        rx_byte_q <= rx_sh_d;
                        rx_stb_q <= 1'b1;
                    end
                end
            end
        end
    end

    assign tx_serial_out_o = tx_q;
    assign tx_serial_out_oe_o = tx_oe_q;
    assign tx_slot_active_n_o = 1'b0;
    assign tx_slot_active_n_oe_o = ts_q;
    assign rx_pcm_data_o = rx_byte_q;
    assign rx_pcm_strobe_o = rx_stb_q;
endmodule // ccpcm_top

// [testbench/ccpcm_chk_sva.sv]
// Port-level checks for the codec control port and PCM framing top.
// Assumes one clock domain and the asynchronous active-low reset.
module ccpcm_chk (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic select_n_i,
    input wire logic serial_out_pin_oe_o,
    input wire logic tx_serial_out_oe_o,
    input wire logic tx_slot_active_n_oe_o,
    input wire logic rx_pcm_strobe_o,
    input wire logic sleep_state_o,
    input wire logic [1:0] clock_rate_sel_o,
    input wire logic pcm_echo_o,
    input wire logic audio_loop_o,
    input wire logic amp_enable_o
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (!rst_n_i);
    a_co_float: assert property (select_n_i |-> !serial_out_pin_oe_o)
        else $error("serial output driven while select high");
    a_tx_asleep: assert property (sleep_state_o |-> !tx_serial_out_oe_o)
        else $error("pcm output driven while asleep");
    a_strobe_in_slot: assert property (tx_slot_active_n_oe_o |-> tx_serial_out_oe_o)
        else $error("slot strobe outside transmit slot");
    a_strobe_start: assert property ($rose(tx_slot_active_n_oe_o) |-> $rose(tx_serial_out_oe_o))
        else $error("slot strobe not aligned with slot start");
    a_loop_excl: assert property (audio_loop_o |-> !pcm_echo_o)
        else $error("both loopback modes at once");
    a_rx_pulse: assert property (rx_pcm_strobe_o |=> !rx_pcm_strobe_o)
        else $error("receive strobe longer than one cycle");
    a_amp_awake: assert property (!sleep_state_o |-> amp_enable_o)
        else $error("amplifier off while awake");
    a_rate_hold: assert property (!$stable(clock_rate_sel_o) |-> !$past(select_n_i))
        else $error("rate changed without a transfer");
    a_sleep_hold: assert property ($changed(sleep_state_o) |-> !$past(select_n_i))
        else $error("power state changed without a transfer");
endmodule // ccpcm_chk

bind ccpcm_top ccpcm_chk chk_u (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .select_n_i(select_n_i),
    .serial_out_pin_oe_o(serial_out_pin_oe_o), .tx_serial_out_oe_o(tx_serial_out_oe_o),
    .tx_slot_active_n_oe_o(tx_slot_active_n_oe_o), .rx_pcm_strobe_o(rx_pcm_strobe_o),
    .sleep_state_o(sleep_state_o), .clock_rate_sel_o(clock_rate_sel_o), .pcm_echo_o(pcm_echo_o),
    .audio_loop_o(audio_loop_o), .amp_enable_o(amp_enable_o));

// [testbench/ccpcm_pcm_bus.sv]
// PCM backplane model: free-running bit clock, one frame mark, receive data.
// Assumes clock_i is the system clock; HALF cycles make one bit clock phase.
module ccpcm_pcm_bus #(
    parameter int HALF = 6
) (
    input wire logic clock_i,
    input wire logic go_i,
    input wire logic [7:0] rx_byte_i,
    output logic bit_clk_o,
    output logic frame_mark_o,
    output logic rx_serial_in_o
);
    timeunit 1ns;
    timeprecision 100ps;
    int ph = 0;
    int bitn = 9;
    logic pend = 1'b0;
    initial begin
        bit_clk_o = 1'b0;
        frame_mark_o = 1'b0;
        rx_serial_in_o = 1'b0;
    end
    always @(posedge clock_i) begin
        if (go_i)
            pend <= 1'b1;
        ph <= (ph == HALF - 1) ? 0 : ph + 1;
        if (ph == HALF - 1) begin
            bit_clk_o <= !bit_clk_o;
            if (bit_clk_o && pend) begin
                // Mark rises half a bit ahead of slot bit 0, held one whole bit
                frame_mark_o <= 1'b1;
                pend <= 1'b0;
                bitn <= 0;
            end else if (bit_clk_o) begin
                frame_mark_o <= 1'b0;
            end else begin
                // Data moves at rises; outside the slot the line toggles, not holding stale data
                bitn <= bitn + 1;
                rx_serial_in_o <= (bitn < 8) ? rx_byte_i[7 - bitn] : !rx_serial_in_o;
            end
        end
    end
endmodule // ccpcm_pcm_bus

// [testbench/tb_codec_control_and_pcm_port.sv]
// Self-checking bench for the codec control port and PCM framing top.
// Assumes the backplane model and the bound checker beside the top.
module tb_codec_control_and_pcm_port;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int HALF = 6;
    logic clock_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic ctrl_shift_clk_i = 1'b0;
    logic select_n_i = 1'b1;
    logic serial_in_pin_i = 1'b0;
    logic [7:0] tx_pcm_data_i = 8'h00;
    logic tx_pcm_valid_i = 1'b0;
    logic go = 1'b0;
    logic [7:0] rx_byte = 8'h00;
    wire bit_clk, mark, rx_ser, sdo, sdo_oe, tx_o, tx_oe, sa_n, sa_oe, ready, rx_stb;
    wire sleep, law, inv, ftim, echo, aloop, amp;
    wire [1:0] rate;
    wire [7:0] rx_data;
    wire sdo_wire = sdo_oe ? sdo : 1'bz;
    wire tx_wire = tx_oe ? tx_o : 1'bz;
    int failures = 0;
    int tests_run = 0;
    int seed = 32'h1b31;
    int cyc = 0;
    int sa_cnt = 0;
    logic got_q[$];
    logic [7:0] rx_q[$];
    logic [7:0] exp_q[$];
    logic [7:0] tbl[4] = '{8'h09, 8'h5A, 8'hAC, 8'hFE};
    logic bc_q = 1'b0;
    logic [7:0] r, c, t, e;

    ccpcm_top dut_u (.clock_i(clock_i), .rst_n_i(rst_n_i), .ctrl_shift_clk_i(ctrl_shift_clk_i),
        .select_n_i(select_n_i), .serial_in_pin_i(serial_in_pin_i), .serial_out_pin_o(sdo),
        .serial_out_pin_oe_o(sdo_oe), .bit_clk_i(bit_clk), .tx_frame_mark_i(mark), .rx_frame_mark_i(mark),
        .tx_serial_out_o(tx_o), .tx_serial_out_oe_o(tx_oe), .tx_slot_active_n_o(sa_n),
        .tx_slot_active_n_oe_o(sa_oe), .rx_serial_in_i(rx_ser), .tx_pcm_data_i(tx_pcm_data_i),
        .tx_pcm_valid_i(tx_pcm_valid_i), .tx_pcm_ready_o(ready), .rx_pcm_data_o(rx_data),
        .rx_pcm_strobe_o(rx_stb), .sleep_state_o(sleep), .clock_rate_sel_o(rate), .law_choice_o(law),
        .inversion_off_o(inv), .frame_timing_sel_o(ftim), .pcm_echo_o(echo), .audio_loop_o(aloop),
        .amp_enable_o(amp));
    ccpcm_pcm_bus #(.HALF(HALF)) pcm_u (.clock_i(clock_i), .go_i(go), .rx_byte_i(rx_byte),
        .bit_clk_o(bit_clk), .frame_mark_o(mark), .rx_serial_in_o(rx_ser));

    initial forever #10 clock_i = ~clock_i;

    // --------------------------------------------------------
    // Slot monitor and hang guard
    // --------------------------------------------------------
    always @(posedge clock_i) begin
        cyc <= cyc + 1;
        bc_q <= bit_clk;
        if (sa_oe === 1'b1 && sa_n === 1'b0)
            sa_cnt <= sa_cnt + 1;
        if (bc_q && !bit_clk && tx_oe === 1'b1)
            got_q.push_back(tx_wire);
        if (rx_stb === 1'b1)
            rx_q.push_back(rx_data);
        if (cyc == 30000) begin
            failures++;
            $display("wrong value at %0t: run timed out", $time);
            tally_and_finish();
        end
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic cfg(input logic [7:0] v, input logic s);
        chk({rate, law, inv, ftim, echo, aloop, amp, sleep},
            {v[7:6], v[5], v[4], v[3], v[2], v[1] & ~v[2], ~s | ~v[0], s}, "fields");
    endtask

    // First n bits of a byte, MSB first, data sampled by the device at each shift clock fall
    task automatic xfer(input logic [7:0] b, input int n, output logic [7:0] q);
        q = 8'h00;
        for (int i = 7; i > 7 - n; i--) begin
            @(posedge clock_i);
            serial_in_pin_i <= b[i];
            ctrl_shift_clk_i <= 1'b1;
            repeat (5) @(posedge clock_i);
            q[i] = sdo_wire;
            ctrl_shift_clk_i <= 1'b0;
            repeat (5) @(posedge clock_i);
        end
    endtask

    task automatic cmd(input logic [7:0] b1, input logic [7:0] b2, input int n2, input logic split,
                       output logic [7:0] q);
        @(posedge clock_i);
        select_n_i <= 1'b0;
        xfer(b1, 8, q);
        if (split) begin
            repeat (4) @(posedge clock_i);
            select_n_i <= 1'b1;
            repeat (6) @(posedge clock_i);
            select_n_i <= 1'b0;
        end
        if (n2 > 0)
            xfer(b2, n2, q);
        repeat (4) @(posedge clock_i);
        select_n_i <= 1'b1;
        repeat (6) @(posedge clock_i);
    endtask

    task automatic push(input logic [7:0] d);
        @(posedge clock_i);
        tx_pcm_data_i <= d;
        tx_pcm_valid_i <= 1'b1;
        do @(posedge clock_i); while (ready !== 1'b1);
        tx_pcm_valid_i <= 1'b0;
    endtask

    task tally_and_finish();
        $display("comparisons %0d, mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    initial begin
        repeat (3) @(posedge clock_i);
        rst_n_i <= 1'b1;
        repeat (4) @(posedge clock_i);
        cfg(8'h89, 1'b1);
        $display("defaults test done");
        for (int i = 0; i < 6; i++) begin
            c = (i < 4) ? tbl[i] : (8'($random(seed)) | 8'h08);
            cmd(8'h82, c, 8, 1'b0, r);
            cfg(c, 1'b1);
            cmd(8'h86, 8'h00, 8, 1'b0, r);
            chk(16'(r), 16'(c), "readback");
        end
        cmd(8'h82, ~c, 4, 1'b0, r);
        cfg(c, 1'b1);
        cmd(8'h9E, 8'h00, 8, 1'b0, r);
        chk(16'(r), 16'h0000, "invalid read");
        cmd(8'hD2, 8'h80, 8, 1'b1, r);
        cmd(8'hCA, 8'h80, 8, 1'b0, r);
        cmd(8'hD6, 8'h00, 8, 1'b1, r);
        chk(16'(r), 16'h0080, "slot readback");
        cmd(8'h82, 8'hA8, 8, 1'b0, r);
        $display("control port test done");
        for (int i = 0; i < 4; i++) begin
            e = 8'($random(seed));
            exp_q.push_back(e);
            push(e);
        end
        @(posedge clock_i);
        chk(16'(ready), 16'h0000, "fifo full");
        cmd(8'h00, 8'h00, 0, 1'b0, r);
        cfg(8'hA8, 1'b0);
        for (int f = 1; f <= 7; f++) begin
            if (f == 7) begin
                // Delayed timing with digital loopback echoes the previous frame's byte
                cmd(8'h02, 8'hA4, 8, 1'b0, r);
                cfg(8'hA4, 1'b0);
            end
            rx_byte <= 8'($random(seed));
            got_q.delete();
            rx_q.delete();
            sa_cnt = 0;
            @(posedge clock_i);
            go <= 1'b1;
            @(posedge clock_i);
            go <= 1'b0;
            repeat (30 * HALF) @(posedge clock_i);
            if (f == 1) begin
                chk(16'(got_q.size() + rx_q.size() + sa_cnt), 16'h0000, "first frame");
            end else begin
                e = (f <= 5) ? exp_q.pop_front() : ((f == 6) ? 8'hD5 : c);
                t = 8'h00;
                foreach (got_q[k]) t = {t[6:0], got_q[k]};
                chk(16'(got_q.size()), 16'h0008, "tx bits");
                chk(16'(t), 16'(e), "tx byte");
                chk(16'(sa_cnt), 16'(15 * HALF), "strobe width");
                chk(16'(rx_q.size()), 16'h0001, "rx count");
                if (rx_q.size() > 0)
                    chk(16'(rx_q[0]), 16'(rx_byte), "rx byte");
            end
            c = rx_byte;
        end
        $display("pcm test done");
        tally_and_finish();
    end
endmodule // tb_codec_control_and_pcm_port
